// *** core/ssc_pkg.sv ***
// package: register map, field layout, reset values and bus/link carriers
package ssc_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned CNT_W     = 5;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0]  OFF_CTL   = 8'h00;
    localparam logic [7:0]  OFF_EN    = 8'h04;
    localparam logic [7:0]  OFF_STAT  = 8'h08;
    localparam logic [7:0]  OFF_TXD   = 8'h0C;
    localparam logic [7:0]  OFF_RXD   = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CTL_MODE  = 6;
    localparam int unsigned CTL_SOFT  = 5;
    localparam int unsigned EN_TX     = 7;
    localparam int unsigned EN_RX     = 6;
    localparam int unsigned ST_OVR    = 6;
    localparam int unsigned ST_TXEND  = 3;
    localparam int unsigned ST_TEMPTY = 2;
    localparam int unsigned ST_RFULL  = 1;
    localparam int unsigned ST_CONF   = 0;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [7:0]  CTL_RESET = 8'h00;
    localparam logic [1:0]  LEN_8     = 2'h0;
    localparam logic [1:0]  LEN_16    = 2'h1;
    localparam logic [1:0]  LEN_32    = 2'h2;
    localparam logic [4:0]  LAST_8    = 5'h07;
    localparam logic [4:0]  LAST_16   = 5'h0F;
    localparam logic [4:0]  LAST_32   = 5'h1F;
    localparam logic [4:0]  ALIGN_8   = 5'h18;
    localparam logic [4:0]  ALIGN_16  = 5'h10;
    localparam logic [4:0]  ALIGN_32  = 5'h00;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ssc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } ssc_apb_rsp_t;

    typedef struct packed {
        logic sel_n;
        logic data;
    } ssc_link_in_t;

    typedef struct packed {
        logic data;
        logic data_en;
    } ssc_link_out_t;

endpackage : ssc_pkg

// *** core/ssc_sync.sv ***
// three-stage synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
module ssc_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // foreign-domain input
    input  wire logic [W-1:0] d,
    // settled level and one-cycle change pulse per bit
    output logic      [W-1:0] q,
    output logic      [W-1:0] chg
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    wire  [W-1:0] agree   = ff2 ~^ ff3;
    wire  [W-1:0] next_q  = (ff3 & agree) | (q & ~agree);

    // ff1 feeds ff2 only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            q   <= '0;
            chg <= '0;
        end
        else
        begin
            ff1 <= d;
            ff2 <= ff1;
            ff3 <= ff2;
            q   <= next_q;
            chg <= next_q ^ q;
        end
    end

endmodule : ssc_sync

// *** core/ssc_core.sv ***
// synchronous serial unit: control-low register, apb slave and link sequencer
//
// Behaviour
// R1 - the top bit of the control-low register always reads as 0.
// R2 - bits four to two of the control-low register always read as 0.
// R3 - bit six picks select-line mode (0, the reset value) or plain clocked mode (1).
// R4 - writing 1 to bit five resets the link sequencer and the bit then clears itself.
// R5 - that soft reset also returns the five status flags and both enables to reset.
// R6 - that soft reset leaves every other register bit untouched.
// R7 - software stops a transfer in progress by issuing the soft reset.
// R8 - the two low bits give the word length: 00 is 8, 01 is 16, 10 is 32 bits.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ssc_core
(
    // apb side
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire ssc_pkg::ssc_apb_req_t apb_req,
    output ssc_pkg::ssc_apb_rsp_t      apb_rsp,
    // link side
    input  wire logic                  link_clk,
    input  wire ssc_pkg::ssc_link_in_t link_in,
    output ssc_pkg::ssc_link_out_t     link_out
);
    import ssc_pkg::*;

    // ****************************************
    // register state (pclk)
    // ****************************************
    logic        ctl_mode;
    logic [1:0]  ctl_len;
    logic        soft_reset;
    logic        soft_tgl;
    logic        tx_en;
    logic        rx_en;
    logic [3:0]  irq_en;
    logic        overrun;
    logic        tx_end;
    logic        tx_empty;
    logic        rx_full;
    logic        conflict;
    logic [31:0] tx_hold;
    logic [31:0] rx_data;
    logic        req_tgl;

    // ****************************************
    // link state (link_clk)
    // ****************************************
    logic [4:0]  bit_cnt;
    logic [31:0] tx_shift;
    logic [31:0] rx_shift;
    logic [31:0] rx_hold;
    logic        ack_tgl;
    logic        done_tgl;
    logic        conf_tgl;

    // ****************************************
    // crossings
    // ****************************************
    logic [5:0]  l_ctl;
    logic [5:0]  l_chg;
    logic [2:0]  p_evt_q;
    logic [2:0]  p_evt;

    ssc_sync #(.W(6)) u_to_link (
        .clk   (link_clk),
        .rst_n (presetn),
        .d     ({soft_tgl, req_tgl, tx_en, ctl_mode, ctl_len}),
        .q     (l_ctl),
        .chg   (l_chg)
    );

    ssc_sync #(.W(3)) u_to_apb (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({conf_tgl, done_tgl, ack_tgl}),
        .q     (p_evt_q),
        .chg   (p_evt)
    );

    wire         l_soft_chg = l_chg[5];
    wire         l_req      = l_ctl[4];
    wire         l_tx_en    = l_ctl[3];
    wire         l_mode     = l_ctl[2];
    wire  [1:0]  l_len      = l_ctl[1:0];
    wire         p_ack      = p_evt[0];
    wire         p_done     = p_evt[1];
    wire         p_conf     = p_evt[2];

    // ****************************************
    // apb decode
    // ****************************************
    wire         acc        = apb_req.psel & apb_req.penable;
    wire         first_acc  = acc & ~apb_rsp.pready;
    wire         fire       = acc & apb_rsp.pready;
    wire         wr_fire    = fire & apb_req.pwrite;
    wire         rd_fire    = fire & ~apb_req.pwrite;
    wire  [7:0]  addr       = apb_req.paddr;
    wire  [31:0] wdata      = apb_req.pwdata;
    wire         sel_ctl    = addr == OFF_CTL;
    wire         sel_en     = addr == OFF_EN;
    wire         sel_stat   = addr == OFF_STAT;
    wire         sel_txd    = addr == OFF_TXD;
    wire         sel_rxd    = addr == OFF_RXD;
    wire         hit        = sel_ctl | sel_en | sel_stat | sel_txd | sel_rxd;
    wire         wr_ctl     = wr_fire & sel_ctl;
    wire         wr_en      = wr_fire & sel_en;
    wire         wr_stat    = wr_fire & sel_stat;
    // a new word is only accepted while the holding register is free
    wire         txd_take   = wr_fire & sel_txd & tx_en & tx_empty;
    wire         rxd_read   = rd_fire & sel_rxd;
    wire  [7:0]  clr        = wr_stat ? wdata[7:0] : 8'h00;

    // ****************************************
    // read mux
    // ****************************************
    wire  [7:0]  rd_ctl     = {1'b0, ctl_mode, soft_reset, 3'h0, ctl_len}; // R1 R2
    wire  [7:0]  rd_en      = {tx_en, rx_en, 2'h0, irq_en};
    wire  [7:0]  rd_stat    = {1'b0, overrun, 2'h0, tx_end, tx_empty, rx_full, conflict};
    wire  [31:0] rd_mux     = sel_ctl  ? {24'h000000, rd_ctl}  :
                              sel_en   ? {24'h000000, rd_en}   :
                              sel_stat ? {24'h000000, rd_stat} :
                              sel_rxd  ? rx_data               : 32'h00000000;

    // ****************************************
    // apb answer: one wait state, from flops
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            apb_rsp <= '0;
        else
        begin
            apb_rsp.pready  <= first_acc;
            apb_rsp.prdata  <= first_acc ? rd_mux : 32'h00000000;
            apb_rsp.pslverr <= first_acc & ~hit;
        end
    end

    // ****************************************
    // control-low register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_mode   <= CTL_RESET[CTL_MODE];
            ctl_len    <= CTL_RESET[1:0];
            soft_reset <= CTL_RESET[CTL_SOFT];
            soft_tgl   <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_mode <= wdata[CTL_MODE]; // R3
                ctl_len  <= wdata[1:0]; // R8
            end
            // held for one cycle only, then clears itself
            soft_reset <= wr_ctl & wdata[CTL_SOFT]; // R4
            if (wr_ctl & wdata[CTL_SOFT])
                soft_tgl <= ~soft_tgl; // R4 R7
        end
    end

    // ****************************************
    // enable register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_en  <= 1'b0;
            rx_en  <= 1'b0;
            irq_en <= 4'h0;
        end
        else if (soft_reset) // R6
        begin
            tx_en <= 1'b0; // R5
            rx_en <= 1'b0; // R5
        end
        else if (wr_en)
        begin
            tx_en  <= wdata[EN_TX];
            rx_en  <= wdata[EN_RX];
            irq_en <= wdata[3:0];
        end
    end

    // ****************************************
    // status flags: hardware set beats software clear
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overrun  <= 1'b0;
            tx_end   <= 1'b0;
            tx_empty <= 1'b1;
            rx_full  <= 1'b0;
            conflict <= 1'b0;
        end
        else if (soft_reset)
        begin
            overrun  <= 1'b0; // R5
            tx_end   <= 1'b0; // R5
            tx_empty <= 1'b1; // R5
            rx_full  <= 1'b0; // R5
            conflict <= 1'b0; // R5
        end
        else
        begin
            overrun  <= (p_done & rx_en & rx_full) | (overrun & ~clr[ST_OVR]);
            tx_end   <= (p_done & tx_en & tx_empty) | (tx_end & ~clr[ST_TXEND] & ~txd_take);
            tx_empty <= p_ack | (tx_empty & ~txd_take);
            rx_full  <= (p_done & rx_en) | (rx_full & ~clr[ST_RFULL] & ~rxd_read);
            conflict <= p_conf | (conflict & ~clr[ST_CONF]);
        end
    end

    // ****************************************
    // data registers
    // ****************************************
    // tx_hold stays still from a take until the ack or a soft reset sets tx_empty, so the link may read it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_hold <= 32'h00000000;
            req_tgl <= 1'b0;
            rx_data <= 32'h00000000;
        end
        else
        begin
            if (txd_take)
            begin
                tx_hold <= wdata;
                req_tgl <= ~req_tgl;
            end
            // an unread word is kept; the new one is lost and flagged
            if (p_done & rx_en & ~rx_full)
                rx_data <= rx_hold;
        end
    end

    // ****************************************
    // link sequencer
    // ****************************************
    wire         frame_ok   = l_mode | ~link_in.sel_n; // R3
    wire  [4:0]  word_last  = (l_len == LEN_16) ? LAST_16 :
                              (l_len == LEN_32) ? LAST_32 : LAST_8; // R8
    wire  [4:0]  align_sh   = (l_len == LEN_16) ? ALIGN_16 :
                              (l_len == LEN_32) ? ALIGN_32 : ALIGN_8; // R8
    wire         word_end   = bit_cnt == word_last;
    wire         load_tx    = (bit_cnt == 5'h00) & l_tx_en & (l_req != ack_tgl);
    wire  [31:0] next_rx    = {link_in.data, rx_shift[31:1]};
    wire  [31:0] rx_word    = next_rx >> align_sh;
    wire  [4:0]  next_cnt   = word_end ? 5'h00 : 5'(bit_cnt + 5'h01);
    // losing the select line mid-word is a conflict in select-line mode
    wire         sel_lost   = ~frame_ok & (bit_cnt != 5'h00);

    // the link clock may stop between frames; settings, soft reset and a lost select only act on later link edges
    always_ff @(posedge link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_cnt  <= 5'h00;
            tx_shift <= 32'h00000000;
            rx_shift <= 32'h00000000;
            rx_hold  <= 32'h00000000;
            ack_tgl  <= 1'b0;
            done_tgl <= 1'b0;
            conf_tgl <= 1'b0;
            link_out <= '0;
        end
        else if (l_soft_chg)
        begin
            bit_cnt  <= 5'h00; // R4 R7
            tx_shift <= 32'h00000000;
            link_out <= '0;
        end
        else if (frame_ok)
        begin
            bit_cnt          <= next_cnt;
            rx_shift         <= next_rx;
            link_out.data_en <= l_tx_en;
            if (word_end)
            begin
                rx_hold  <= rx_word;
                done_tgl <= ~done_tgl;
            end
            if (load_tx)
            begin
                tx_shift      <= tx_hold >> 1;
                link_out.data <= tx_hold[0];
                ack_tgl       <= ~ack_tgl;
            end
            else
            begin
                tx_shift      <= tx_shift >> 1;
                link_out.data <= tx_shift[0];
            end
        end
        else
        begin
            bit_cnt          <= 5'h00;
            link_out.data_en <= 1'b0;
            if (sel_lost)
                conf_tgl <= ~conf_tgl;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence ctl_read_s;
        first_acc & ~apb_req.pwrite & sel_ctl;
    endsequence

    sequence soft_write_s;
        wr_ctl & wdata[CTL_SOFT];
    endsequence

    sequence soft_pulse_s;
        soft_reset ##1 !soft_reset;
    endsequence

    ctl_top_zero_a: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        ctl_read_s |=> apb_rsp.pready && !apb_rsp.prdata[7])
        else $error("control top bit read as one");
    ctl_resv_zero_a: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        ctl_read_s |=> apb_rsp.prdata[4:2] == 3'h0)
        else $error("control reserved bits read nonzero");
    mode_store_a: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        wr_ctl |=> ctl_mode == $past(wdata[CTL_MODE]) && rd_ctl[CTL_MODE] == ctl_mode)
        else $error("protocol select not stored");
    soft_clear_a: assert property ( // R4
        @(posedge pclk) disable iff (!presetn)
        soft_write_s |=> soft_pulse_s)
        else $error("soft reset bit did not clear itself");
    seq_restart_a: assert property ( // R4
        @(posedge link_clk) disable iff (!presetn)
        l_soft_chg |=> bit_cnt == 5'h00 && !link_out.data_en)
        else $error("link sequencer not reset");
    flags_init_a: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        soft_reset |=> tx_empty && !overrun && !tx_end && !rx_full && !conflict
                       && !tx_en && !rx_en)
        else $error("soft reset left a flag or enable set");
    others_held_a: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        soft_reset && !wr_fire |=> $stable(ctl_mode) && $stable(ctl_len) && $stable(irq_en))
        else $error("soft reset disturbed other bits");
    len_decode_a: assert property ( // R8
        @(posedge link_clk) disable iff (!presetn)
        (l_len == LEN_16 |-> word_last == 5'h0F) and (l_len == LEN_32 |-> word_last == 5'h1F))
        else $error("word length decode wrong");
    len_eight_a: assert property ( // R8
        @(posedge link_clk) disable iff (!presetn)
        frame_ok && l_len == LEN_8 && bit_cnt == 5'h07 && !l_soft_chg |=> bit_cnt == 5'h00)
        else $error("eight-bit word did not end at bit eight");

endmodule : ssc_core

// *** test/ssc_peer.sv ***
// far-side serial peer: clocks frames, shifts its word in and captures the unit's word
`timescale 1ns/1ps
module ssc_peer (
    // clock, select and data towards the unit
    output logic                        link_clk,
    output ssc_pkg::ssc_link_in_t       link_in,
    // data from the unit
    input  wire ssc_pkg::ssc_link_out_t link_out
);
    import ssc_pkg::*;

    initial
    begin
        link_clk = 1'b0;
        link_in  = '{sel_n: 1'b1, data: 1'b0};
    end

    // released data line keeps changing so a stale level never looks like a bit
    initial
    begin
        #5;
        forever #16 if (link_in.sel_n) link_in.data = ~link_in.data;
    end

    // ****************************************
    // one frame, lsb first
    // ****************************************
    // lead-in pulses run with the select high so the unit can cross its settings;
    // the clock stands still otherwise
    task automatic frame(input int nbits, input int lead, input logic [31:0] rx_word,
                         output logic [31:0] tx_word, output int en_bits);
        tx_word = 32'h0;
        en_bits = 0;
        #3;
        repeat (lead)
        begin
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
        end
        link_in.sel_n = 1'b0;
        link_in.data  = rx_word[0];
        for (int i = 0; i < nbits; i++)
        begin
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
            tx_word[i]   = link_out.data;
            if (link_out.data_en)
                en_bits++;
            link_in.data = (i + 1 < nbits) ? rx_word[i + 1] : ~rx_word[i];
        end
        #16 link_in.sel_n = 1'b1;
    endtask : frame

endmodule : ssc_peer

// *** test/sync_serial_control_low_bench.sv ***
// testbench: control register, soft reset and serial transfers against the peer
`timescale 1ns/1ps
module sync_serial_control_low_bench;
    import ssc_pkg::*;

    logic          pclk;
    logic          presetn;
    ssc_apb_req_t  apb_req;
    ssc_apb_rsp_t  apb_rsp;
    logic          link_clk;
    ssc_link_in_t  link_in;
    ssc_link_out_t link_out;
    int            error_cnt;
    int            samples_checked;
    logic [31:0]   rd;
    logic          err;
    logic [31:0]   seen;
    logic [7:0]    w;
    int            en;

    ssc_core DUT (
        .pclk     (pclk),
        .presetn  (presetn),
        .apb_req  (apb_req),
        .apb_rsp  (apb_rsp),
        .link_clk (link_clk),
        .link_in  (link_in),
        .link_out (link_out)
    );

    ssc_peer PEER (
        .link_clk (link_clk),
        .link_in  (link_in),
        .link_out (link_out)
    );

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic stop_test;
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [31:0] mask(input int nb);
        return (nb == 32) ? 32'hFFFFFFFF : ((32'h1 << nb) - 32'h1);
    endfunction : mask

    function automatic logic [31:0] ctl_exp(input logic [7:0] v);
        return {24'h0, 1'b0, v[6], 4'h0, v[1:0]};
    endfunction : ctl_exp

    // the slave's latency is not assumed; only a bounded wait on pready
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            check("pready", 32'h1, 32'h0);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    task automatic rreg(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0);
        check(what, exp, rd);
        check("slverr", 32'h0, {31'h0, err});
    endtask : rreg

    task automatic xfer(input int len, input logic md);
        int          nb;
        logic [31:0] txw;
        logic [31:0] rxw;
        nb  = 8 << len;
        txw = $urandom;
        rxw = $urandom;
        // plain clocked mode has no select to frame a word; a soft reset lines up the count
        apb(1'b1, OFF_CTL, {24'h0, 1'b0, md, md, 3'h0, 2'(len)});
        apb(1'b1, OFF_EN, 32'hC0);
        apb(1'b1, OFF_TXD, txw);
        rreg(OFF_STAT, 32'h00, "stat loaded");
        // plain mode: the fifth link edge applies the soft reset, the sixth carries bit zero
        PEER.frame(nb, md ? 5 : 6, rxw, seen, en);
        repeat (10) @(posedge pclk);
        check("tx word", txw & mask(nb), seen);
        check("tx enable bits", nb, en);
        rreg(OFF_STAT, 32'h0E, "stat done");
        rreg(OFF_RXD, rxw & mask(nb), "rx word");
    endtask : xfer

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        error_cnt       = 0;
        samples_checked = 0;
        presetn         = 1'b0;
        apb_req         = '0;
        void'($urandom(57682));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rreg(OFF_CTL, 32'h00, "ctl reset");
        rreg(OFF_STAT, 32'h04, "stat reset");
        rreg(OFF_EN, 32'h00, "en reset");
        apb(1'b0, 8'hF0, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped read", 32'h0, rd);
        // reserved bits written with random values on purpose; every mode and legal length code
        for (int i = 0; i < 12; i++)
        begin
            w      = $urandom;
            w[6]   = i[0];
            w[1:0] = 2'(i % 3);
            apb(1'b1, OFF_CTL, {24'h0, w});
            rreg(OFF_CTL, ctl_exp(w), "ctl readback");
        end
        for (int len = 0; len < 3; len++)
            xfer(len, 1'b0);
        // soft reset with flags and enables set: mode and length survive
        apb(1'b1, OFF_EN, 32'hCF);
        apb(1'b1, OFF_CTL, 32'h62);
        rreg(OFF_CTL, 32'h42, "ctl after soft reset");
        rreg(OFF_EN, 32'h0F, "en after soft reset");
        rreg(OFF_STAT, 32'h04, "stat after soft reset");
        // stop a 32-bit transfer midway, then a clean word must still pass
        apb(1'b1, OFF_CTL, 32'h02);
        apb(1'b1, OFF_EN, 32'hC0);
        apb(1'b1, OFF_TXD, $urandom);
        fork
            PEER.frame(32, 6, $urandom, seen, en);
            begin
                repeat (20) @(posedge pclk);
                apb(1'b1, OFF_CTL, 32'h22);
            end
        join
        // select rose mid-word with the link clock stopped; the next edge reports it
        PEER.frame(0, 6, 32'h0, seen, en);
        repeat (10) @(posedge pclk);
        rreg(OFF_EN, 32'h00, "en after abort");
        rreg(OFF_STAT, 32'h05, "stat cut word");
        apb(1'b1, OFF_STAT, 32'h4B);
        rreg(OFF_STAT, 32'h04, "stat after abort");
        xfer(0, 1'b0);
        xfer(int'($urandom % 3), 1'b1);
        stop_test();
    end

    // tests need about 15 us; some thirteen times that means a hang
    initial
    begin
        #200000;
        error_cnt++;
        stop_test();
    end

endmodule : sync_serial_control_low_bench
